/* File: pkg/pbc_pkg.sv */
// Shared constants and types for the bypass control and event counter block.
// Assumes one management clock domain and an SMI (MDC/MDIO) host outside.
package pbc_pkg;

  // Register offsets on the management interface
  localparam logic [4:0]  REG_BYPASS     = 5'h12;
  localparam logic [4:0]  REG_RX_ERR_CNT = 5'h13;
  localparam logic [4:0]  REG_FCAR_CNT   = 5'h14;
  localparam logic [4:0]  REG_LDROP_CNT  = 5'h15;

  // Bypass control field positions
  localparam int BIT_TX_DISABLE   = 15;
  localparam int BIT_BYP_4B5B     = 14;
  localparam int BIT_BYP_SCRAM    = 13;
  localparam int BIT_BYP_DESCRAM  = 12;
  localparam int BIT_BYP_PCS_RX   = 11;
  localparam int BIT_BYP_PCS_TX   = 10;
  localparam int BIT_BYP_LFHT     = 9;
  localparam int BIT_XOVER_FORCED = 7;
  localparam int BIT_NONCOMP_OFF  = 6;
  localparam int BIT_PAIR_SWAP    = 5;
  localparam int BIT_POLARITY     = 4;
  localparam int BIT_PAR_DETECT   = 3;
  localparam int BIT_PULSE_SHAPE  = 2;
  localparam int BIT_NP_MANUAL    = 1;

  // Values after reset and access masks of the bypass register
  localparam logic [15:0] BYPASS_RESET   = 16'h0088;
  localparam logic [15:0] BYPASS_WR_MASK = 16'hFEFE;
  localparam logic [15:0] BYPASS_STICKY  = 16'h00FA;

  // Event counters
  localparam int          CNT_NUM   = 3;
  localparam int          CNT_W     = 8;
  localparam logic [7:0]  CNT_MAX   = 8'hFF;
  localparam logic [7:0]  CNT_RESET = 8'h00;
  localparam logic [7:0]  CNT_ONE   = 8'h01;

  // Serial management frame
  localparam logic [5:0]  PREAMBLE_LEN = 6'h20;
  localparam logic [5:0]  HDR_BITS     = 6'h0C;
  localparam logic [5:0]  TA_BITS      = 6'h02;
  localparam logic [5:0]  DATA_BITS    = 6'h10;
  localparam logic [1:0]  OP_READ      = 2'h2;
  localparam logic [1:0]  OP_WRITE     = 2'h1;

  typedef enum logic [2:0] {
    SMI_IDLE  = 3'b000,
    SMI_START = 3'b001,
    SMI_HDR   = 3'b010,
    SMI_TA    = 3'b011,
    SMI_DATA  = 3'b100
  } pbc_smi_state_t;

endpackage

/* File: pkg/pbc_cnt_if.sv */
// Carrier between the register logic and one saturating event counter.
// Assumes both ends share the management clock.
`timescale 1ns/1ps
`default_nettype none
interface pbc_cnt_if;
  logic       inc;
  logic       clr;
  logic [7:0] value;

  modport counter (
    input  inc,
    input  clr,
    output value
  );

  modport reader (
    output inc,
    output clr,
    input  value
  );
endinterface
`default_nettype wire

/* File: core/pbc_event_counter.sv */
// One 8-bit saturating event counter, cleared on a management read.
// Assumes inc and clr are one-cycle pulses on clk.
`timescale 1ns/1ps
`default_nettype none
module pbc_event_counter (
  input  wire logic     clk,
  input  wire logic     rst_n,
  input  wire logic     ce,
  input  wire logic     soft_rst,
  pbc_cnt_if.counter    bus
);
  import pbc_pkg::*;

  typedef struct packed {
    logic [7:0] count;
  } pbc_cnt_state_t;

  pbc_cnt_state_t cnt_reg;
  pbc_cnt_state_t cnt_next;

  always_comb begin
    cnt_next = cnt_reg;
    if (soft_rst) begin
      cnt_next.count = CNT_RESET;
    // R17 clear on read
    end else if (bus.clr) begin
      // Event in the clearing cycle is kept, not lost
      cnt_next.count = bus.inc ? CNT_ONE : CNT_RESET;
    // R16 saturate at 255
    end else if (bus.inc && cnt_reg.count != CNT_MAX) begin
      cnt_next.count = cnt_reg.count + CNT_ONE;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '{count: CNT_RESET};
    end else if (ce) begin
      cnt_reg <= cnt_next;
    end
  end

  assign bus.value = cnt_reg.count;
endmodule
`default_nettype wire

/* File: core/pbc_top.sv */
// Bypass control register and three event counters behind an SMI slave.
// Assumes mdc/mdio/phy_addr are pins; events and soft reset are on clk.
//
// Notes on behaviour
// R01 - Bypass bit 15 set turns the line transmitter off; resets zero, read/write.
// R02 - Bits 14, 13, 12 bypass block coder, scrambler, descrambler; reset zero.
// R03 - Bit 11 bypasses receive PCS, bit 10 transmit PCS; both reset zero.
// R04 - Bit 9 set skips the link fail hold timer; resets zero.
// R05 - Sticky bit 7, reset one, disables auto crossover at forced 10/100.
// R06 - Sticky bit 6 set turns off non-compliant gigabit partner detection.
// R07 - Sticky bit 5 set disables automatic pair swap correction.
// R08 - Sticky bit 4 set stops per-subchannel polarity correction.
// R09 - Sticky bit 3, reset one: one honours advertised abilities in parallel detect.
// R10 - Bit 2 set disables the transmit pulse shaping filter; resets zero.
// R11 - Sticky bit 1 set stops automatic gigabit next pages; host takes over.
// R12 - Host then sends next pages, resolves abilities, forces configuration.
// R13 - Register 0x13 low byte counts 100/1000 receive errors; resets zero.
// R14 - Register 0x14 low byte counts 100/1000 false carriers; resets zero.
// R15 - Register 0x15 low byte counts copper link disconnects; resets zero.
// R16 - Each counter holds at 255 and never wraps.
// R17 - Reading a counter returns its value then clears it.
// R18 - Sticky bits survive soft reset when sticky reset enable is set.
// R19 - Reserved bits read zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
module pbc_top (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire logic       mdc,
  input  wire logic       mdio_i,
  output var  logic       mdio_o,
  output var  logic       mdio_oe,
  input  wire logic [4:0] phy_addr,
  input  wire logic       soft_reset,
  input  wire logic       sticky_reset_en,
  input  wire logic       forced_10_100,
  input  wire logic       rx_err_evt,
  input  wire logic       false_carrier_evt,
  input  wire logic       link_drop_evt,
  output var  logic       tx_disable,
  output var  logic       bypass_block_code,
  output var  logic       bypass_scrambler,
  output var  logic       bypass_descrambler,
  output var  logic       bypass_pcs_rx,
  output var  logic       bypass_pcs_tx,
  output var  logic       skip_link_fail_hold_timer,
  output var  logic       auto_crossover_off,
  output var  logic       noncompliant_detect_off,
  output var  logic       pair_swap_fix_off,
  output var  logic       polarity_fix_off,
  output var  logic       parallel_detect_honour,
  output var  logic       pulse_shaping_off,
  output var  logic       next_page_manual
);
  import pbc_pkg::*;

  typedef struct packed {
    logic                  mdc_s1;
    logic                  mdc_s2;
    logic                  mdc_s3;
    logic                  dio_s1;
    logic                  dio_s2;
    logic [4:0]            pad_s1;
    logic [4:0]            pad_s2;
    pbc_smi_state_t        fsm;
    logic [5:0]            bitcnt;
    logic [15:0]           shreg;
    logic                  is_read;
    logic                  is_write;
    logic                  hit;
    logic [4:0]            regad;
    logic [CNT_NUM-1:0]    cnt_clr;
    logic [15:0]           bypass;
    logic                  xover_off;
    logic                  dout;
    logic                  doe;
  } pbc_state_t;

  localparam pbc_state_t STATE_RESET = '{
    mdc_s1:    1'b0,
    mdc_s2:    1'b0,
    mdc_s3:    1'b0,
    dio_s1:    1'b1,
    dio_s2:    1'b1,
    pad_s1:    5'h00,
    pad_s2:    5'h00,
    fsm:       SMI_IDLE,
    bitcnt:    6'h00,
    shreg:     16'h0000,
    is_read:   1'b0,
    is_write:  1'b0,
    hit:       1'b0,
    regad:     5'h00,
    cnt_clr:   '0,
    bypass:    BYPASS_RESET,
    xover_off: 1'b1,
    dout:      1'b1,
    doe:       1'b0
  };

  pbc_state_t st_reg;
  pbc_state_t st_next;

  logic [CNT_NUM-1:0] evt_vec;
  logic [7:0]         cnt_val [CNT_NUM];
  logic               mdc_rise;
  logic [CNT_NUM-1:0] rd_sel;
  logic [15:0]        rd_data;

  // One-hot counter select from a register address
  function automatic logic [CNT_NUM-1:0] cnt_sel(input logic [4:0] a);
    logic [CNT_NUM-1:0] s;
    s    = '0;
    s[0] = (a == REG_RX_ERR_CNT);
    s[1] = (a == REG_FCAR_CNT);
    s[2] = (a == REG_LDROP_CNT);
    return s;
  endfunction

  // R13 receive errors
  // R14 false carriers
  // R15 link disconnects
  assign evt_vec = {link_drop_evt, false_carrier_evt, rx_err_evt};

  pbc_cnt_if cnt_bus [CNT_NUM] ();

  genvar g;
  for (g = 0; g < CNT_NUM; g++) begin : g_cnt
    assign cnt_bus[g].inc = evt_vec[g];
    assign cnt_bus[g].clr = st_reg.cnt_clr[g];
    assign cnt_val[g]     = cnt_bus[g].value;

    pbc_event_counter u_cnt (
      .clk      (clk),
      .rst_n    (rst_n),
      .ce       (ce),
      .soft_rst (soft_reset),
      .bus      (cnt_bus[g])
    );
  end

  // Only synchronised copies are looked at
  assign mdc_rise = st_reg.mdc_s2 && !st_reg.mdc_s3;

  // Read mux on the decoded address and live counter values; sampled at the first turnaround bit
  always_comb begin
    rd_sel  = cnt_sel(st_reg.regad);
    rd_data = 16'h0000;
    if (st_reg.regad == REG_BYPASS) begin
      // R19 reserved bits read zero
      rd_data = st_reg.bypass & BYPASS_WR_MASK;
    end
    for (int i = 0; i < CNT_NUM; i++) begin
      if (rd_sel[i]) begin
        // R13 upper byte reserved
        rd_data = {8'h00, cnt_val[i]};
      end
    end
  end

  always_comb begin
    st_next         = st_reg;
    st_next.cnt_clr = '0;

    st_next.mdc_s1 = mdc;
    st_next.mdc_s2 = st_reg.mdc_s1;
    st_next.mdc_s3 = st_reg.mdc_s2;
    st_next.dio_s1 = mdio_i;
    st_next.dio_s2 = st_reg.dio_s1;
    st_next.pad_s1 = phy_addr;
    st_next.pad_s2 = st_reg.pad_s1;

    if (mdc_rise) begin
      unique case (st_reg.fsm)
        SMI_IDLE: begin
          st_next.doe = 1'b0;
          if (st_reg.dio_s2) begin
            if (st_reg.bitcnt != PREAMBLE_LEN) begin
              st_next.bitcnt = st_reg.bitcnt + 6'h01;
            end
          end else if (st_reg.bitcnt == PREAMBLE_LEN) begin
            st_next.fsm = SMI_START;
          end else begin
            st_next.bitcnt = 6'h00;
          end
        end
        SMI_START: begin
          st_next.bitcnt = 6'h00;
          st_next.fsm    = st_reg.dio_s2 ? SMI_HDR : SMI_IDLE;
        end
        SMI_HDR: begin
          st_next.shreg  = {st_reg.shreg[14:0], st_reg.dio_s2};
          st_next.bitcnt = st_reg.bitcnt + 6'h01;
          if (st_reg.bitcnt == HDR_BITS - 6'h01) begin
            st_next.fsm    = SMI_TA;
            st_next.bitcnt = 6'h00;
          end
        end
        SMI_TA: begin
          st_next.bitcnt = st_reg.bitcnt + 6'h01;
          if (st_reg.bitcnt == 6'h00) begin
            // Read: drive the zero of the turnaround
            st_next.doe  = st_reg.is_read && st_reg.hit;
            st_next.dout = 1'b0;
            // R17 capture value and clear counter
            if (st_reg.is_read && st_reg.hit) begin
              st_next.shreg   = rd_data;
              st_next.cnt_clr = rd_sel;
            end
          end else begin
            st_next.dout   = st_reg.shreg[15];
            st_next.shreg  = {st_reg.shreg[14:0], 1'b0};
            st_next.fsm    = SMI_DATA;
            st_next.bitcnt = 6'h00;
          end
        end
        SMI_DATA: begin
          st_next.bitcnt = st_reg.bitcnt + 6'h01;
          if (st_reg.is_read) begin
            st_next.dout  = st_reg.shreg[15];
            st_next.shreg = {st_reg.shreg[14:0], 1'b0};
          end else begin
            st_next.shreg = {st_reg.shreg[14:0], st_reg.dio_s2};
          end
          if (st_reg.bitcnt == DATA_BITS - 6'h01) begin
            st_next.fsm    = SMI_IDLE;
            st_next.bitcnt = 6'h00;
            st_next.doe    = 1'b0;
            st_next.dout   = 1'b1;
            if (st_reg.is_write && st_reg.hit &&
                st_reg.regad == REG_BYPASS) begin
              // R19 reserved bits ignore writes
              st_next.bypass = {st_reg.shreg[14:0], st_reg.dio_s2}
                               & BYPASS_WR_MASK;
            end
          end
        end
        default: begin
          st_next.fsm    = SMI_IDLE;
          st_next.bitcnt = 6'h00;
          st_next.doe    = 1'b0;
        end
      endcase
    end

    // Header complete: decode opcode, address match and register
    if (mdc_rise && st_reg.fsm == SMI_HDR &&
        st_reg.bitcnt == HDR_BITS - 6'h01) begin
      st_next.is_read  = (st_reg.shreg[10:9] == OP_READ);
      st_next.is_write = (st_reg.shreg[10:9] == OP_WRITE);
      st_next.hit      = (st_reg.shreg[8:4] == st_reg.pad_s2);
      st_next.regad    = {st_reg.shreg[3:0], st_reg.dio_s2};
      if (!((st_reg.shreg[10:9] == OP_READ) ||
            (st_reg.shreg[10:9] == OP_WRITE))) begin
        st_next.fsm = SMI_IDLE;
      end
    end

    // R05 crossover off only at forced speed
    st_next.xover_off = st_reg.bypass[BIT_XOVER_FORCED] && forced_10_100;

    // R18 sticky bits kept when enabled
    if (soft_reset) begin
      if (sticky_reset_en) begin
        st_next.bypass = (st_reg.bypass & BYPASS_STICKY)
                         | (BYPASS_RESET & ~BYPASS_STICKY);
      end else begin
        st_next.bypass = BYPASS_RESET;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= STATE_RESET;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign mdio_o  = st_reg.dout;
  assign mdio_oe = st_reg.doe;

  // R01 transmitter off
  assign tx_disable                = st_reg.bypass[BIT_TX_DISABLE];
  // R02 coding stage bypass
  assign bypass_block_code         = st_reg.bypass[BIT_BYP_4B5B];
  assign bypass_scrambler          = st_reg.bypass[BIT_BYP_SCRAM];
  assign bypass_descrambler        = st_reg.bypass[BIT_BYP_DESCRAM];
  // R03 PCS bypass
  assign bypass_pcs_rx             = st_reg.bypass[BIT_BYP_PCS_RX];
  assign bypass_pcs_tx             = st_reg.bypass[BIT_BYP_PCS_TX];
  // R04 hold timer skip
  assign skip_link_fail_hold_timer = st_reg.bypass[BIT_BYP_LFHT];
  // R05 crossover disable
  assign auto_crossover_off        = st_reg.xover_off;
  // R06 partner detection off
  assign noncompliant_detect_off   = st_reg.bypass[BIT_NONCOMP_OFF];
  // R07 pair swap off
  assign pair_swap_fix_off         = st_reg.bypass[BIT_PAIR_SWAP];
  // R08 polarity fix off
  assign polarity_fix_off          = st_reg.bypass[BIT_POLARITY];
  // R09 parallel detect mode
  assign parallel_detect_honour    = st_reg.bypass[BIT_PAR_DETECT];
  // R10 pulse shaping off
  assign pulse_shaping_off         = st_reg.bypass[BIT_PULSE_SHAPE];
  // R11 manual next pages
  assign next_page_manual          = st_reg.bypass[BIT_NP_MANUAL];
endmodule
`default_nettype wire

/* File: test/pbc_top_asserts.sv */
// Checker on the top pins: soft reset defaults and the serial answer.
// Assumes it is bound into pbc_top; one clock, async low reset.
`timescale 1ns/1ps
`default_nettype none
module pbc_top_asserts (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic mdio_o,
  input wire logic mdio_oe,
  input wire logic soft_reset,
  input wire logic sticky_reset_en,
  input wire logic forced_10_100,
  input wire logic tx_disable,
  input wire logic bypass_block_code,
  input wire logic bypass_pcs_tx,
  input wire logic skip_link_fail_hold_timer,
  input wire logic auto_crossover_off,
  input wire logic noncompliant_detect_off,
  input wire logic parallel_detect_honour,
  input wire logic next_page_manual
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Low ce freezes state, so only enabled cycles count
  sequence srst; soft_reset && ce; endsequence
  sequence srst_clear; srst ##0 !sticky_reset_en; endsequence
  sequence srst_keep; srst ##0 sticky_reset_en; endsequence
  sequence ta_hold; !mdio_o ##1 mdio_oe [*7]; endsequence

  txoff_default_a:
    assert property (srst |=> !tx_disable)
    else $error("transmit disable kept over soft reset");
  coder_default_a:
    assert property (srst |=> !bypass_block_code)
    else $error("coder bypass kept over soft reset");
  pcs_default_a:
    assert property (srst |=> !bypass_pcs_tx)
    else $error("pcs bypass kept over soft reset");
  timer_default_a:
    assert property (srst |=> !skip_link_fail_hold_timer)
    else $error("timer skip kept over soft reset");
  xover_forced_a:
    assert property ($past(rst_n) && $past(ce) && !$past(forced_10_100)
                     |-> !auto_crossover_off)
    else $error("crossover off at free speed");
  xover_restore_a:
    assert property (srst_clear ##1 (forced_10_100 && ce)
                     |=> auto_crossover_off)
    else $error("crossover not off after default");
  sticky_default_a:
    assert property (srst_clear |=> parallel_detect_honour
                     && !noncompliant_detect_off && !next_page_manual)
    else $error("sticky bits not back to defaults");
  sticky_keep_a:
    assert property (srst_keep |=> $stable({noncompliant_detect_off,
                     parallel_detect_honour, next_page_manual}))
    else $error("sticky bits lost over soft reset");
  answer_hold_a:
    assert property ($rose(mdio_oe) |-> ta_hold)
    else $error("read answer cut short");
endmodule

bind pbc_top pbc_top_asserts u_pbc_top_asserts (
  .clk(clk), .rst_n(rst_n), .ce(ce), .mdio_o(mdio_o),
  .mdio_oe(mdio_oe), .soft_reset(soft_reset),
  .sticky_reset_en(sticky_reset_en), .forced_10_100(forced_10_100),
  .tx_disable(tx_disable), .bypass_block_code(bypass_block_code),
  .bypass_pcs_tx(bypass_pcs_tx),
  .skip_link_fail_hold_timer(skip_link_fail_hold_timer),
  .auto_crossover_off(auto_crossover_off),
  .noncompliant_detect_off(noncompliant_detect_off),
  .parallel_detect_honour(parallel_detect_honour),
  .next_page_manual(next_page_manual)
);
`default_nettype wire

/* File: test/pbc_smi_host.sv */
// Management host model: preamble, header and data on MDC and MDIO.
// Assumes the bench merges both enables onto one pulled-up line.
`timescale 1ns/1ps
`default_nettype none
module pbc_smi_host (
  input  wire logic clk,
  input  wire logic mdio_line,
  output var  logic mdc,
  output var  logic host_oe,
  output var  logic host_val
);
  import pbc_pkg::*;
  initial {mdc, host_oe, host_val} = 3'b001;

  // Six clocks a phase, slow enough for the pin synchronisers
  task automatic cyc(input logic en, input logic b, output logic s);
    host_oe = en;
    host_val = b;
    repeat (6) @(posedge clk);
    #1 mdc = 1'b1;
    s = mdio_line;
    repeat (6) @(posedge clk);
    #1 mdc = 1'b0;
  endtask

  task automatic frame(input logic [1:0] op, input logic [4:0] pa,
                       input logic [4:0] ra, input logic [15:0] wd,
                       output logic [15:0] rd);
    logic [13:0] hdr;
    logic        s;
    hdr = {2'b01, op, pa, ra};
    rd = 16'h0000;
    for (int i = 0; i < 32; i++)
      cyc(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--)
      cyc(1'b1, hdr[i], s);
    if (op == OP_WRITE) begin
      cyc(1'b1, 1'b1, s);
      cyc(1'b1, 1'b0, s);
      for (int i = 15; i >= 0; i--)
        cyc(1'b1, wd[i], s);
    end else begin
      cyc(1'b0, 1'b1, s);
      cyc(1'b0, 1'b1, s);
      for (int i = 15; i >= 0; i--) begin
        cyc(1'b0, 1'b1, s);
        rd[i] = s;
      end
    end
    // Idle tail of two released cycles; a write has already committed during the last data bit
    cyc(1'b0, 1'b1, s);
    cyc(1'b0, 1'b1, s);
  endtask
endmodule
`default_nettype wire

/* File: test/pbc_top_tb.sv */
// Bench: model of bypass bits and counters checked at pins and reads.
// Assumes the host model makes the frames; MDIO has a pull-up.
`timescale 1ns/1ps
`default_nettype none
module pbc_top_tb;
  import pbc_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        ce = 1'b1;
  logic        srst = 1'b0;
  logic        keep = 1'b1;
  logic        forced = 1'b0;
  logic [2:0]  evt = 3'h0;
  logic [4:0]  pa = 5'h05;
  logic [15:0] byp = BYPASS_RESET;
  logic [15:0] d, v;
  wire         mdc, h_oe, h_val, m_o, m_oe, mdio;
  wire  [15:0] outs;
  int          num_errors = 0, checked = 0, seed = 63;
  int          cnt [3] = '{0, 0, 0};

  always #4 clk = ~clk;
  // Released line reads one through the pull-up
  assign mdio = m_oe ? m_o : (h_oe ? h_val : 1'b1);

  pbc_top u_pbc_top (
    .clk(clk), .rst_n(rst_n), .ce(ce), .mdc(mdc), .mdio_i(mdio),
    .mdio_o(m_o), .mdio_oe(m_oe), .phy_addr(pa), .soft_reset(srst),
    .sticky_reset_en(keep), .forced_10_100(forced),
    .rx_err_evt(evt[0]), .false_carrier_evt(evt[1]),
    .link_drop_evt(evt[2]), .tx_disable(outs[15]),
    .bypass_block_code(outs[14]), .bypass_scrambler(outs[13]),
    .bypass_descrambler(outs[12]), .bypass_pcs_rx(outs[11]),
    .bypass_pcs_tx(outs[10]), .skip_link_fail_hold_timer(outs[9]),
    .auto_crossover_off(outs[7]), .noncompliant_detect_off(outs[6]),
    .pair_swap_fix_off(outs[5]), .polarity_fix_off(outs[4]),
    .parallel_detect_honour(outs[3]), .pulse_shaping_off(outs[2]),
    .next_page_manual(outs[1])
  );
  pbc_smi_host u_pbc_smi_host (
    .clk(clk), .mdio_line(mdio), .mdc(mdc), .host_oe(h_oe),
    .host_val(h_val)
  );

  task automatic chk(input string what, input logic [15:0] e,
                     input logic [15:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask
  // Bits 8 and 0 have no pin
  task automatic pins;
    chk("pins", {byp[15:8], byp[7] & forced, byp[6:0]},
        outs & 16'hFEFE);
  endtask
  task automatic rchk(input logic [4:0] ra, input logic [4:0] p,
                      input logic [15:0] e);
    u_pbc_smi_host.frame(OP_READ, p, ra, 16'h0000, v);
    chk($sformatf("reg %h", ra), e, v);
  endtask
  task automatic wr(input logic [4:0] ra, input logic [4:0] p,
                    input logic [15:0] w);
    u_pbc_smi_host.frame(OP_WRITE, p, ra, w, v);
  endtask
  task automatic ccnt(input int i);
    rchk(5'(REG_RX_ERR_CNT + i), pa, 16'(cnt[i]));
    cnt[i] = 0;
  endtask
  task automatic fire(input int n, input logic [2:0] m, input bit rnd);
    repeat (n) begin
      evt = m;
      ce = rnd ? 1'($random(seed)) : 1'b1;
      for (int i = 0; i < 3; i++)
        if (m[i] && ce)
          cnt[i] = cnt[i] < 255 ? cnt[i] + 1 : 255;
      @(posedge clk);
      #1;
    end
    evt = 3'h0;
    ce = 1'b1;
  endtask
  task automatic sr(input logic k);
    keep = k;
    srst = 1'b1;
    @(posedge clk);
    #1 srst = 1'b0;
    byp = k ? (byp & BYPASS_STICKY) | (BYPASS_RESET & ~BYPASS_STICKY)
            : BYPASS_RESET;
    cnt = '{0, 0, 0};
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic conclude;
    if (num_errors == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // About 45 frames of 800 clocks, twice over
  initial begin
    #(45 * 800 * 8 * 2);
    num_errors++;
    conclude;
  end

  initial begin
    repeat (16) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clk);
    #1 pins;
    rchk(REG_BYPASS, pa, BYPASS_RESET);
    for (int i = 0; i < 3; i++)
      ccnt(i);
    for (int i = 0; i < 5; i++) begin
      d = i == 0 ? 16'hFFFF : i == 1 ? 16'h0000 : 16'($random(seed));
      forced = 1'($random(seed));
      wr(REG_BYPASS, pa, d);
      byp = d & BYPASS_WR_MASK;
      pins;
      rchk(REG_BYPASS, pa, byp);
    end
    wr(REG_BYPASS, pa ^ 5'h01, 16'h0000);
    rchk(REG_BYPASS, pa, byp);
    rchk(5'h1F, pa, 16'h0000);
    fire(7, 3'b001, 1'b0);
    wr(REG_RX_ERR_CNT, pa, 16'h00AA);
    for (int k = 0; k < 3; k++) begin
      fire(1 + ($random(seed) & 63), 3'($random(seed)), 1'b1);
      for (int i = 0; i < 6; i++)
        ccnt(i % 3);
    end
    fire(300, 3'b111, 1'b0);
    for (int i = 0; i < 3; i++)
      ccnt(i);
    wr(REG_BYPASS, pa, 16'hFFFF);
    byp = BYPASS_WR_MASK;
    fire(3, 3'b111, 1'b0);
    sr(1'b1);
    pins;
    forced = 1'b1;
    sr(1'b0);
    pins;
    for (int i = 0; i < 3; i++)
      ccnt(i);
    rchk(REG_BYPASS, pa, byp);
    conclude;
  end
endmodule
`default_nettype wire
